/* File: rtl/hostctl_cfg.svh */
`ifndef HOSTCTL_CFG_SVH
`define HOSTCTL_CFG_SVH

// Clock rate and reset timing
`define CLK_PERIOD_PS 5000
`define RESET_MIN_NS 300
`define READY_DELAY_MS 5
// Worked in ns and ns per clock so no term leaves 32-bit range
`define READY_CYCLES ((`READY_DELAY_MS * 1000000) / (`CLK_PERIOD_PS / 1000))

// Serial frame layout
`define CMD_BITS 8
`define ADDR_BITS 8
`define DATA_BITS 8
`define CMD_READ 8'h03
`define CMD_WRITE 8'h02

// Register map of this block
`define ADDR_STATUS 8'h00
`define STATUS_READY_BIT 7
`define ADDR_HI_PEND 8'h01
`define ADDR_LO_PEND 8'h02
`define ADDR_HI_EN 8'h03
`define ADDR_LO_EN 8'h04
`define ADDR_CTRL 8'h05
`define CTRL_PHY_RST_BIT 0
`define ADDR_SCRATCH 8'h06
`define REG_COUNT 8
`define EN_RESET 8'h00
`define CTRL_RESET 8'h01

`endif

/* File: rtl/hostctl_pkg.sv */
`default_nettype none
package hostctl_pkg;
    typedef logic [7:0] byte_t;

    // Serial frame state, link side
    typedef enum logic [1:0] {
        SER_CMD,
        SER_ADDR,
        SER_DATA,
        SER_DONE
    } ser_state_e;

    // Access request carried from the link domain to the core
    typedef struct packed {
        logic write;
        byte_t addr;
        byte_t data;
    } access_s;
endpackage : hostctl_pkg
`default_nettype wire

/* File: rtl/scratch_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hostctl_cfg.svh"

// Small register store with registered read data
module scratch_mem
    import hostctl_pkg::*;
(
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [2:0] waddr_in,
    input wire byte_t wdata_in,
    input wire logic [2:0] raddr_in,
    output byte_t rdata_out
);
    byte_t mem [0:`REG_COUNT-1];

    // Write port
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    // Registered read
    always_ff @(posedge clk_in) begin
        rdata_out <= mem[raddr_in];
    end
endmodule : scratch_mem
`default_nettype wire

/* File: rtl/host_control_reset_interface.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hostctl_cfg.svh"

module host_control_reset_interface
    import hostctl_pkg::*;
#(
    parameter int READY_CYCLES = `READY_CYCLES
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic device_reset_n_in,
    input wire logic [7:0] hi_event_in,
    input wire logic [7:0] lo_event_in,
    input wire logic sclk_in,
    input wire logic select_n_in,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_oe_out,
    output logic ethernet_transceiver_reset_n_out,
    output logic [1:0] irq_o_out,
    output logic [1:0] irq_oe_out,
    output logic ready_out
);
    // ==========================================================
    // Reset pin synchroniser and combined core reset
    // ==========================================================
    logic rstn_meta_reg;
    logic rstn_sync_reg;
    logic core_rst;

    // Pin is asynchronous to mclk, so two flops first
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rstn_meta_reg <= 1'b0;
            rstn_sync_reg <= 1'b0;
        end else begin
            rstn_meta_reg <= device_reset_n_in;
            rstn_sync_reg <= rstn_meta_reg;
        end
    end

    assign core_rst = rst_in | ~rstn_sync_reg;

    // ==========================================================
    // Reset-ready counter
    // ==========================================================
    logic [31:0] ready_cnt_reg;
    logic ready_reg;

    // Wait the fixed delay before opening register writes
    always_ff @(posedge mclk_in) begin
        if (core_rst) begin
            ready_cnt_reg <= 32'h0;
            ready_reg <= 1'b0;
        end else if (!ready_reg) begin
            if (ready_cnt_reg >= 32'(READY_CYCLES - 1)) begin
                ready_reg <= 1'b1;
            end
            ready_cnt_reg <= ready_cnt_reg + 32'h1;
        end
    end

    // ==========================================================
    // Link domain: serial frame receive and transmit
    // ==========================================================
    ser_state_e ser_state_reg;
    logic [2:0] bit_cnt_reg;
    byte_t shift_reg;
    byte_t cmd_reg;
    access_s req_reg;
    logic req_tgl_reg;
    logic rd_req_tgl_reg;
    byte_t tx_reg;
    logic tx_en_reg;
    logic [2:0] tx_cnt_reg;
    byte_t shift_next;

    assign shift_next = {shift_reg[6:0], serial_in};

    // Sample on rising sclk; select high holds the frame idle.
    // Select acts as the frame's asynchronous end, since sclk stops.
    always_ff @(posedge sclk_in or posedge select_n_in) begin
        if (select_n_in) begin
            ser_state_reg <= SER_CMD;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                case (ser_state_reg)
                    SER_CMD: begin
                        ser_state_reg <= SER_ADDR;
                    end
                    SER_ADDR: begin
                        ser_state_reg <= (cmd_reg == `CMD_WRITE) ?
                            SER_DATA : SER_DONE;
                    end
                    SER_DATA: begin
                        ser_state_reg <= SER_DONE;
                    end
                    default: begin
                        ser_state_reg <= SER_DONE;
                    end
                endcase
            end
        end
    end

    // Command, address and write capture; requests cross as toggles.
    // Reset levels the toggles so the core sees no false request.
    always_ff @(posedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_reg <= 8'h00;
            req_reg <= '0;
            req_tgl_reg <= 1'b0;
            rd_req_tgl_reg <= 1'b0;
        end else if (!select_n_in && bit_cnt_reg == 3'h7) begin
            case (ser_state_reg)
                SER_CMD: begin
                    cmd_reg <= shift_next;
                end
                SER_ADDR: begin
                    req_reg.addr <= shift_next;
                    req_reg.write <= 1'b0;
                    if (cmd_reg == `CMD_READ) begin
                        rd_req_tgl_reg <= ~rd_req_tgl_reg;
                    end
                end
                SER_DATA: begin
                    req_reg.data <= shift_next;
                    req_reg.write <= 1'b1;
                    req_tgl_reg <= ~req_tgl_reg;
                end
                default: begin
                    cmd_reg <= cmd_reg;
                end
            endcase
        end
    end

    // Read data leaves on falling sclk so the host samples it rising.
    // The read word settles about four mclk after the request toggle
    // and then holds; half an sclk period covers that, so sclk must
    // stay well below mclk / 8.
    byte_t rd_data_reg;
    always_ff @(negedge sclk_in or posedge select_n_in) begin
        if (select_n_in) begin
            tx_en_reg <= 1'b0;
            tx_cnt_reg <= 3'h0;
            tx_reg <= 8'h00;
        end else if (ser_state_reg == SER_DONE && cmd_reg == `CMD_READ) begin
            if (!tx_en_reg) begin
                tx_en_reg <= 1'b1;
                tx_reg <= rd_data_reg;
                tx_cnt_reg <= 3'h0;
            end else if (tx_cnt_reg != 3'h7) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg + 3'h1;
            end
        end
    end

    assign serial_out = tx_reg[7];
    assign serial_oe_out = tx_en_reg;

    // ==========================================================
    // Crossing into the core domain
    // ==========================================================
    logic [2:0] wr_tgl_sync_reg;
    logic [2:0] rd_tgl_sync_reg;
    logic wr_pulse;
    logic rd_pulse;

    // Request struct is stable long before its toggle is seen
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_tgl_sync_reg <= 3'h0;
            rd_tgl_sync_reg <= 3'h0;
        end else begin
            wr_tgl_sync_reg <= {wr_tgl_sync_reg[1:0], req_tgl_reg};
            rd_tgl_sync_reg <= {rd_tgl_sync_reg[1:0], rd_req_tgl_reg};
        end
    end

    assign wr_pulse = wr_tgl_sync_reg[2] ^ wr_tgl_sync_reg[1];
    assign rd_pulse = rd_tgl_sync_reg[2] ^ rd_tgl_sync_reg[1];

    // ==========================================================
    // Registers, pending status and interrupts
    // ==========================================================
    byte_t hi_pend_reg;
    byte_t lo_pend_reg;
    byte_t hi_en_reg;
    byte_t lo_en_reg;
    byte_t ctrl_reg;
    byte_t mem_rdata;
    logic wr_ok;
    logic mem_we;
    logic [2:0] mem_waddr;
    byte_t mem_wdata;
    localparam byte_t SCRATCH_SLOT = `ADDR_SCRATCH;

    // Writes before ready are dropped; reads are still served
    assign wr_ok = wr_pulse & ready_reg & req_reg.write;
    // Reset writes zero into the scratch word, its default
    assign mem_we = core_rst || (wr_ok && req_reg.addr == `ADDR_SCRATCH);
    assign mem_waddr = core_rst ? SCRATCH_SLOT[2:0] : req_reg.addr[2:0];
    assign mem_wdata = core_rst ? 8'h00 : req_reg.data;

    // Settings back to defaults under reset
    always_ff @(posedge mclk_in) begin
        if (core_rst) begin
            hi_en_reg <= `EN_RESET;
            lo_en_reg <= `EN_RESET;
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_ok) begin
            case (req_reg.addr)
                `ADDR_HI_EN: hi_en_reg <= req_reg.data;
                `ADDR_LO_EN: lo_en_reg <= req_reg.data;
                `ADDR_CTRL: ctrl_reg <= req_reg.data;
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Sticky pending; write one clears, a new event wins over the clear
    always_ff @(posedge mclk_in) begin
        if (core_rst) begin
            hi_pend_reg <= 8'h00;
            lo_pend_reg <= 8'h00;
        end else begin
            hi_pend_reg <= (hi_pend_reg &
                ~((wr_ok && req_reg.addr == `ADDR_HI_PEND) ?
                req_reg.data : 8'h00)) | hi_event_in;
            lo_pend_reg <= (lo_pend_reg &
                ~((wr_ok && req_reg.addr == `ADDR_LO_PEND) ?
                req_reg.data : 8'h00)) | lo_event_in;
        end
    end

    // Read mux, registered; held for the link to pick up
    always_ff @(posedge mclk_in) begin
        if (core_rst) begin
            rd_data_reg <= 8'h00;
        end else if (rd_pulse) begin
            case (req_reg.addr)
                `ADDR_STATUS: rd_data_reg <= 8'(ready_reg) <<
                    `STATUS_READY_BIT;
                `ADDR_HI_PEND: rd_data_reg <= hi_pend_reg;
                `ADDR_LO_PEND: rd_data_reg <= lo_pend_reg;
                `ADDR_HI_EN: rd_data_reg <= hi_en_reg;
                `ADDR_LO_EN: rd_data_reg <= lo_en_reg;
                `ADDR_CTRL: rd_data_reg <= ctrl_reg;
                `ADDR_SCRATCH: rd_data_reg <= mem_rdata;
                default: rd_data_reg <= 8'h00;
            endcase
        end
    end

    scratch_mem u_mem (
        .clk_in(mclk_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(req_reg.addr[2:0]),
        .rdata_out(mem_rdata)
    );

    // Output flops: open-drain drives low only while asserted
    always_ff @(posedge mclk_in) begin
        if (core_rst) begin
            irq_oe_out <= 2'b00;
            ethernet_transceiver_reset_n_out <= 1'b0;
            ready_out <= 1'b0;
        end else begin
            irq_oe_out[0] <= |(hi_pend_reg & hi_en_reg);
            irq_oe_out[1] <= |(lo_pend_reg & lo_en_reg);
            ethernet_transceiver_reset_n_out <=
                ~ctrl_reg[`CTRL_PHY_RST_BIT];
            ready_out <= ready_reg;
        end
    end

    // Output level is always low; enable alone decides assertion
    always_ff @(posedge mclk_in) begin
        irq_o_out <= 2'b00;
    end
endmodule : host_control_reset_interface
`default_nettype wire

/* File: tb/hostctl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks of the host control block
module hostctl_asserts #(
    parameter int READY_CYCLES = 20
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic device_reset_n_in,
    input wire logic [7:0] hi_event_in,
    input wire logic [7:0] lo_event_in,
    input wire logic sclk_in,
    input wire logic select_n_in,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_oe_out,
    input wire logic ethernet_transceiver_reset_n_out,
    input wire logic [1:0] irq_o_out,
    input wire logic [1:0] irq_oe_out,
    input wire logic ready_out
);
    int up_reg;
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in || !device_reset_n_in);
    // Cycles since reset let go; saturates so it never wraps
    always_ff @(posedge mclk_in) begin
        if (rst_in || !device_reset_n_in)
            up_reg <= 0;
        else if (up_reg < READY_CYCLES + 9)
            up_reg <= up_reg + 1;
    end
    a_reset_state: assert property (disable iff (1'b0)
        (rst_in || !device_reset_n_in) [*6] |-> !ready_out
        && irq_oe_out == 2'b00 && !ethernet_transceiver_reset_n_out)
        else $error("outputs not at reset values");
    a_open_drain: assert property (irq_o_out == 2'b00)
        else $error("interrupt line driven high");
    a_ready_early: assert property (
        ready_out |-> up_reg >= READY_CYCLES)
        else $error("ready too early");
    a_ready_late: assert property (
        up_reg >= READY_CYCLES + 8 |-> ready_out)
        else $error("ready missing");
    a_hi_cause: assert property ($rose(irq_oe_out[0]) |->
        !select_n_in || $past(|hi_event_in, 1) || $past(|hi_event_in, 2)
        || $past(|hi_event_in, 3) || $past(|hi_event_in, 4))
        else $error("high interrupt without high event");
    a_lo_cause: assert property ($rose(irq_oe_out[1]) |->
        !select_n_in || $past(|lo_event_in, 1) || $past(|lo_event_in, 2)
        || $past(|lo_event_in, 3) || $past(|lo_event_in, 4))
        else $error("low interrupt without low event");
    // Only a host write (inside a frame) may drop an interrupt
    a_irq_hold: assert property (
        |(~irq_oe_out & $past(irq_oe_out)) |->
        !select_n_in || $past(!select_n_in, 4))
        else $error("interrupt dropped without host access");
    a_idle_quiet: assert property (
        select_n_in [*4] |-> !serial_oe_out)
        else $error("output driven while deselected");
    a_drive_frame: assert property (
        $rose(serial_oe_out) |-> !select_n_in)
        else $error("output enabled outside a frame");
    a_bit_shift: assert property (
        serial_oe_out && $past(serial_oe_out) && $changed(serial_out)
        |-> $fell(sclk_in))
        else $error("read bit changed off falling clock");
    c_ready: cover property ($rose(ready_out));
    c_irq: cover property ($rose(irq_oe_out[1]));
    c_read: cover property ($rose(serial_oe_out));
endmodule : hostctl_asserts

bind host_control_reset_interface hostctl_asserts #(
    .READY_CYCLES(READY_CYCLES)
) u_chk (
    .mclk_in, .rst_in, .device_reset_n_in, .hi_event_in, .lo_event_in,
    .sclk_in, .select_n_in, .serial_in, .serial_out, .serial_oe_out,
    .ethernet_transceiver_reset_n_out, .irq_o_out, .irq_oe_out, .ready_out
);
`default_nettype wire

/* File: tb/serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hostctl_cfg.svh"
// ==========
// Host side of the serial port
module serial_host_model
    import hostctl_pkg::*;
(
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic sclk_out,
    output logic select_n_out,
    output logic si_out
);
    // Idle: deselected, clock parked low
    initial begin
        sclk_out = 1'b0;
        select_n_out = 1'b1;
        si_out = 1'b0;
    end
    // One frame; quiet keeps select high to send stray traffic
    task automatic xfer(input logic quiet, input logic wr,
                        input byte_t adr, input byte_t wd,
                        output byte_t rd);
        logic [23:0] sh;
        sh = {wr ? `CMD_WRITE : `CMD_READ, adr, wd};
        rd = 8'h00;
        #1.3;
        select_n_out = quiet;
        for (int i = 0; i < 24; i++) begin
            si_out = (i < 16 || wr) ? sh[23 - i] : ~si_out;
            #40 sclk_out = 1'b1;
            // A released line reads as the inverse of the last bit
            if (i >= 16)
                rd = {rd[6:0], so_oe_in ? so_in : ~rd[0]};
            #40 sclk_out = 1'b0;
        end
        #40 select_n_out = 1'b1;
        si_out = ~si_out;
        #160;
    endtask : xfer
endmodule : serial_host_model
`default_nettype wire

/* File: tb/host_control_reset_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hostctl_cfg.svh"
// ==========
// Bench for the host control block
module host_control_reset_interface_tb import hostctl_pkg::*;;
    localparam int RDY = 2000;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic dev_rst_n = 1'b0;
    byte_t hi_ev = 8'h00;
    byte_t lo_ev = 8'h00;
    logic sclk, sel_n, si, so, so_oe, eth_rst_n, rdy;
    logic [1:0] irq_o, irq_oe;
    int mismatches = 0;
    int cmp_count = 0;
    int seed = 65;
    byte_t m, ev, x;

    always #2.5 mclk_in = ~mclk_in;

    host_control_reset_interface #(.READY_CYCLES(RDY)) dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .device_reset_n_in(dev_rst_n),
        .hi_event_in(hi_ev), .lo_event_in(lo_ev), .sclk_in(sclk),
        .select_n_in(sel_n), .serial_in(si), .serial_out(so),
        .serial_oe_out(so_oe), .ethernet_transceiver_reset_n_out(eth_rst_n),
        .irq_o_out(irq_o), .irq_oe_out(irq_oe), .ready_out(rdy));
    serial_host_model host (.so_in(so), .so_oe_in(so_oe), .sclk_out(sclk),
        .select_n_out(sel_n), .si_out(si));

    // Expected interrupt lines for one priority
    function automatic logic [1:0] irq_exp(input int p, input byte_t e,
                                           input byte_t k);
        return (|(e & k)) ? 2'b01 << p : 2'b00;
    endfunction : irq_exp
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input byte_t a, input byte_t d);
        byte_t y;
        host.xfer(1'b0, 1'b1, a, d, y);
    endtask : wr
    task automatic rd_chk(input byte_t a, input byte_t exp);
        byte_t y;
        host.xfer(1'b0, 1'b0, a, 8'h00, y);
        check(y, exp);
    endtask : rd_chk
    // Bounded wait instead of the fixed delay
    task automatic wait_ready;
        for (int n = 0; n < RDY + 100 && rdy !== 1'b1; n++)
            @(negedge mclk_in);
        check({7'h0, rdy}, 8'h01);
    endtask : wait_ready
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // Watchdog, well beyond the expected run
    initial begin
        #400000;
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge mclk_in);
        rst_in = 1'b0;
        check({4'h0, rdy, eth_rst_n, irq_oe}, 8'h00);
        repeat (40) @(negedge mclk_in);
        dev_rst_n = 1'b1; // 300 ns low after power-up
        wr(`ADDR_SCRATCH, 8'h5A); // dropped, not ready yet
        rd_chk(`ADDR_STATUS, 8'h00);
        wait_ready();
        rd_chk(`ADDR_STATUS, 8'h80);
        rd_chk(`ADDR_SCRATCH, 8'h00);
        rd_chk(`ADDR_HI_EN, `EN_RESET);
        rd_chk(`ADDR_LO_EN, `EN_RESET);
        rd_chk(`ADDR_CTRL, `CTRL_RESET);
        check({7'h0, eth_rst_n}, 8'h00);
        wr(`ADDR_CTRL, 8'h00);
        check({7'h0, eth_rst_n}, 8'h01);
        rd_chk(8'h07, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ev = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            wr(`ADDR_SCRATCH, ev);
            rd_chk(`ADDR_SCRATCH, ev);
        end
        host.xfer(1'b1, 1'b1, `ADDR_SCRATCH, ~ev, x);
        rd_chk(`ADDR_SCRATCH, ev);
        // Both priorities: masked, random and sure hits
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                m = (k == 0) ? 8'h00 : 8'($random(seed)) | 8'h01;
                ev = (k == 2) ? 8'h01 : 8'($random(seed)) | 8'h80;
                wr(p ? `ADDR_LO_EN : `ADDR_HI_EN, m);
                @(negedge mclk_in);
                if (p) lo_ev = ev; else hi_ev = ev;
                @(negedge mclk_in);
                hi_ev = 8'h00;
                lo_ev = 8'h00;
                repeat (6) @(negedge mclk_in);
                check({6'h0, irq_oe}, {6'h0, irq_exp(p, ev, m)});
                check({6'h0, irq_o}, 8'h00);
                rd_chk(p ? `ADDR_LO_PEND : `ADDR_HI_PEND, ev);
                check({6'h0, irq_oe}, {6'h0, irq_exp(p, ev, m)});
                wr(p ? `ADDR_LO_PEND : `ADDR_HI_PEND, ev);
                check({6'h0, irq_oe}, 8'h00);
            end
        end
        // Pin reset in mid-run with an interrupt pending
        wr(`ADDR_HI_EN, 8'hFF);
        @(negedge mclk_in);
        hi_ev = 8'h10;
        @(negedge mclk_in);
        hi_ev = 8'h00;
        repeat (6) @(negedge mclk_in);
        check({6'h0, irq_oe}, 8'h01);
        dev_rst_n = 1'b0;
        repeat (60) @(negedge mclk_in);
        check({4'h0, rdy, eth_rst_n, irq_oe}, 8'h00);
        dev_rst_n = 1'b1;
        wait_ready();
        rd_chk(`ADDR_HI_EN, `EN_RESET);
        rd_chk(`ADDR_HI_PEND, 8'h00);
        rd_chk(`ADDR_CTRL, `CTRL_RESET);
        close_out();
    end
endmodule : host_control_reset_interface_tb
`default_nettype wire
